// file: src/tcc_pkg.sv
/*
 * tcc_pkg: register offsets, field positions, reset values and modes of the
 * 16-bit capture/compare timer.
 * assumes: byte-wide register port, offsets are byte indices on that port.
 */
package tcc_pkg;
    // register offsets (byte index on the register port)
    localparam logic [3:0] TCC_OFS_CTRL_B    = 4'h1;
    localparam logic [3:0] TCC_OFS_CTRL_A    = 4'h2;
    localparam logic [3:0] TCC_OFS_STATUS    = 4'h3;
    localparam logic [3:0] TCC_OFS_CAP_A_HI  = 4'h4;
    localparam logic [3:0] TCC_OFS_CAP_A_LO  = 4'h5;
    localparam logic [3:0] TCC_OFS_CMP_A_HI  = 4'h6;
    localparam logic [3:0] TCC_OFS_CMP_A_LO  = 4'h7;
    localparam logic [3:0] TCC_OFS_CNT_HI    = 4'h8;
    localparam logic [3:0] TCC_OFS_CNT_LO    = 4'h9;
    localparam logic [3:0] TCC_OFS_ACNT_HI   = 4'ha;
    localparam logic [3:0] TCC_OFS_ACNT_LO   = 4'hb;
    localparam logic [3:0] TCC_OFS_CAP_B_HI  = 4'hc;
    localparam logic [3:0] TCC_OFS_CAP_B_LO  = 4'hd;
    localparam logic [3:0] TCC_OFS_CMP_B_HI  = 4'he;
    localparam logic [3:0] TCC_OFS_CMP_B_LO  = 4'hf;
    // control A fields
    localparam int TCC_A_CAP_IE   = 7;
    localparam int TCC_A_CMP_IE   = 6;
    localparam int TCC_A_OVF_IE   = 5;
    localparam int TCC_A_FORCE_B  = 4;
    localparam int TCC_A_FORCE_A  = 3;
    localparam int TCC_A_LEVEL_B  = 2;
    localparam int TCC_A_CAP_A_ED = 1;
    localparam int TCC_A_LEVEL_A  = 0;
    // control B fields
    localparam int TCC_B_OUT_A_EN = 7;
    localparam int TCC_B_OUT_B_EN = 6;
    localparam int TCC_B_SPULSE   = 5;
    localparam int TCC_B_PWM      = 4;
    localparam int TCC_B_CLK_HI   = 3;
    localparam int TCC_B_CLK_LO   = 2;
    localparam int TCC_B_CAP_B_ED = 1;
    localparam int TCC_B_EXT_ED   = 0;
    // status fields
    localparam int TCC_S_CAP_A  = 7;
    localparam int TCC_S_MATCH_A = 6;
    localparam int TCC_S_OVF    = 5;
    localparam int TCC_S_CAP_B  = 4;
    localparam int TCC_S_MATCH_B = 3;
    localparam int TCC_S_FREEZE = 2;
    // clock selects
    localparam logic [1:0] TCC_CLK_DIV4 = 2'h0;
    localparam logic [1:0] TCC_CLK_DIV2 = 2'h1;
    localparam logic [1:0] TCC_CLK_DIV8 = 2'h2;
    localparam logic [1:0] TCC_CLK_EXT  = 2'h3;
    // reset values, counter limits and prescaler masks
    localparam logic [7:0]  TCC_RST_CTRL  = 8'h00;
    localparam logic [15:0] TCC_RST_CMP   = 16'h8000;
    localparam logic [15:0] TCC_RST_CNT   = 16'hfffc;
    localparam logic [15:0] TCC_CNT_MAX   = 16'hffff;
    localparam logic [15:0] TCC_CNT_ZERO  = 16'h0000;
    localparam logic [2:0]  TCC_PRE_DIV2  = 3'h1;
    localparam logic [2:0]  TCC_PRE_DIV4  = 3'h3;
    localparam logic [2:0]  TCC_PRE_DIV8  = 3'h7;
endpackage

// file: src/tcc_timer.sv
/*
 * tcc_timer: 16-bit free-running timer, two captures, two compares,
 * single-pulse and pwm modes, prescaler and external clock.
 * assumes: one clock clk_sys, byte register port with one-cycle read data,
 * pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
#(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // cpu side
    input  wire logic       cpu_irq_mask,
    output logic            timer_irq,
    // pins
    input  wire logic       capture_a_pin,
    input  wire logic       capture_b_pin,
    input  wire logic       ext_count_pin,
    output logic            compare_a_pin,
    output logic            compare_a_pin_oe,
    output logic            compare_b_pin,
    output logic            compare_b_pin_oe
);
    // pin synchronisers: three stages, change counts when 2nd and 3rd agree
    logic [2:0] sync_r [3];
    logic [2:0] sync_nxt [3];
    logic [2:0] stable_r;
    logic [2:0] stable_nxt;
    logic [2:0] pin_in;
    assign pin_in = {ext_count_pin, capture_b_pin, capture_a_pin};

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sync_nxt[i] = {sync_r[i][1:0], pin_in[i]};
            stable_nxt[i] = (sync_r[i][1] == sync_r[i][2]) ? sync_r[i][2] : stable_r[i];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                sync_r[i] <= 3'h0;
            end
            stable_r <= 3'h0;
        end else begin
            sync_r   <= sync_nxt;
            stable_r <= stable_nxt;
        end
    end

    function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
        edge_hit = rising ? (!prev && now) : (prev && !now);
    endfunction

    // registers and state
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_a_nxt;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  ctrl_b_nxt;
    logic [4:0]  flags_r;
    logic [4:0]  flags_nxt;
    logic [4:0]  armed_r;
    logic [4:0]  armed_nxt;
    logic        freeze_r;
    logic        freeze_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] cap_a_r;
    logic [15:0] cap_a_nxt;
    logic [15:0] cap_b_r;
    logic [15:0] cap_b_nxt;
    logic [15:0] cmp_a_r;
    logic [15:0] cmp_a_nxt;
    logic [15:0] cmp_b_r;
    logic [15:0] cmp_b_nxt;
    logic [15:0] pwm_a_r;
    logic [15:0] pwm_a_nxt;
    logic [15:0] pwm_b_r;
    logic [15:0] pwm_b_nxt;
    logic [1:0]  inhibit_r;
    logic [1:0]  inhibit_nxt;
    logic [7:0]  latch_r;
    logic [7:0]  latch_nxt;
    // low byte held from a count high read until the low read
    logic        hold_r;
    logic        hold_nxt;
    logic [2:0]  pre_r;
    logic [2:0]  pre_nxt;
    logic [2:0]  prev_r;
    logic [2:0]  prev_nxt;
    logic        pulse_act_r;
    logic        pulse_act_nxt;
    logic        pin_a_r;
    logic        pin_a_nxt;
    logic        pin_b_r;
    logic        pin_b_nxt;
    logic        oe_a_r;
    logic        oe_a_nxt;
    logic        oe_b_r;
    logic        oe_b_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    // flag index order inside flags_r: 4 cap_a, 3 match_a, 2 ovf, 1 cap_b, 0 match_b
    logic        pwm_mode, sp_mode, tick, ext_edge, cap_a_ev, cap_b_ev;
    logic        match_a, match_b, wr_cnt;
    logic [2:0]  pre_mask;
    logic [4:0]  set_ev, clr_ev;
    logic [4:0]  acc_lo;

    always_comb begin
        pwm_mode = ctrl_b_r[TCC_B_PWM];
        sp_mode  = ctrl_b_r[TCC_B_SPULSE] && !pwm_mode;
        unique case (ctrl_b_r[TCC_B_CLK_HI:TCC_B_CLK_LO])
            TCC_CLK_DIV4: pre_mask = TCC_PRE_DIV4;
            TCC_CLK_DIV2: pre_mask = TCC_PRE_DIV2;
            TCC_CLK_DIV8: pre_mask = TCC_PRE_DIV8;
            TCC_CLK_EXT:  pre_mask = TCC_PRE_DIV8;
        endcase
        ext_edge = HAS_EXT_CLK && edge_hit(prev_r[2], stable_r[2], ctrl_b_r[TCC_B_EXT_ED]);
        if (freeze_r) begin
            tick = 1'b0;
        end else if (ctrl_b_r[TCC_B_CLK_HI:TCC_B_CLK_LO] == TCC_CLK_EXT) begin
            tick = ext_edge;
        end else begin
            tick = ((pre_r & pre_mask) == pre_mask);
        end
        cap_a_ev = edge_hit(prev_r[0], stable_r[0], ctrl_a_r[TCC_A_CAP_A_ED]);
        cap_b_ev = edge_hit(prev_r[1], stable_r[1], ctrl_b_r[TCC_B_CAP_B_ED]);
        match_a  = tick && !inhibit_r[0] && (cnt_r == (pwm_mode ? pwm_a_r : cmp_a_r));
        match_b  = tick && !inhibit_r[1] && (cnt_r == (pwm_mode ? pwm_b_r : cmp_b_r));
        acc_lo   = '0;
        wr_cnt   = reg_wr && (reg_addr == TCC_OFS_CNT_LO || reg_addr == TCC_OFS_ACNT_LO);
        if (reg_wr || reg_rd) begin
            acc_lo[4] = (reg_addr == TCC_OFS_CAP_A_LO);
            acc_lo[3] = (reg_addr == TCC_OFS_CMP_A_LO);
            acc_lo[2] = (reg_addr == TCC_OFS_CNT_LO);
            acc_lo[1] = (reg_addr == TCC_OFS_CAP_B_LO);
            acc_lo[0] = (reg_addr == TCC_OFS_CMP_B_LO);
        end
        clr_ev = armed_r & acc_lo;
        set_ev[4] = (cap_a_ev && !pwm_mode) || (pwm_mode && match_b);
        set_ev[3] = match_a && !pwm_mode && !sp_mode;
        set_ev[2] = tick && (cnt_r == TCC_CNT_MAX) && !(pwm_mode && match_b);
        set_ev[1] = cap_b_ev;
        set_ev[0] = match_b && !pwm_mode;
    end

    // next state
    always_comb begin
        ctrl_a_nxt = ctrl_a_r;
        ctrl_b_nxt = ctrl_b_r;
        freeze_nxt = freeze_r;
        cmp_a_nxt  = cmp_a_r;
        cmp_b_nxt  = cmp_b_r;
        pwm_a_nxt  = pwm_a_r;
        pwm_b_nxt  = pwm_b_r;
        inhibit_nxt = inhibit_r;
        latch_nxt  = latch_r;
        hold_nxt   = hold_r;
        cap_a_nxt  = cap_a_r;
        cap_b_nxt  = cap_b_r;
        pin_a_nxt  = pin_a_r;
        pin_b_nxt  = pin_b_r;
        pulse_act_nxt = pulse_act_r;
        prev_nxt   = stable_r;
        pre_nxt    = freeze_r ? pre_r : pre_r + 3'h1;
        cnt_nxt    = tick ? cnt_r + 16'h0001 : cnt_r;
        // set wins over clear
        flags_nxt  = (flags_r & ~clr_ev) | set_ev;
        armed_nxt  = (armed_r & ~acc_lo) & ~set_ev;
        rdata_nxt  = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                TCC_OFS_CTRL_A:   rdata_nxt = ctrl_a_r;
                TCC_OFS_CTRL_B:   rdata_nxt = ctrl_b_r;
                TCC_OFS_STATUS:   rdata_nxt = {flags_r[4:0], freeze_r, 2'h0};
                TCC_OFS_CAP_A_HI: rdata_nxt = cap_a_r[15:8];
                TCC_OFS_CAP_A_LO: rdata_nxt = cap_a_r[7:0];
                TCC_OFS_CMP_A_HI: rdata_nxt = cmp_a_r[15:8];
                TCC_OFS_CMP_A_LO: rdata_nxt = cmp_a_r[7:0];
                TCC_OFS_CMP_B_HI: rdata_nxt = cmp_b_r[15:8];
                TCC_OFS_CMP_B_LO: rdata_nxt = cmp_b_r[7:0];
                TCC_OFS_CNT_HI,
                TCC_OFS_ACNT_HI:  rdata_nxt = cnt_r[15:8];
                TCC_OFS_CNT_LO,
                TCC_OFS_ACNT_LO:  rdata_nxt = latch_r;
                TCC_OFS_CAP_B_HI: rdata_nxt = cap_b_r[15:8];
                TCC_OFS_CAP_B_LO: rdata_nxt = cap_b_r[7:0];
                default:          rdata_nxt = 8'h00;
            endcase
            if (reg_addr == TCC_OFS_CNT_HI || reg_addr == TCC_OFS_ACNT_HI) begin
                latch_nxt = cnt_r[7:0];
                hold_nxt  = 1'b1;
            end
            if (reg_addr == TCC_OFS_STATUS) begin
                armed_nxt = flags_r & ~set_ev;
            end
        end
        if (reg_rd && (reg_addr == TCC_OFS_CNT_LO || reg_addr == TCC_OFS_ACNT_LO)) begin
            hold_nxt = 1'b0;
        end
        // captures
        if (cap_a_ev && !pwm_mode && !sp_mode) begin
            cap_a_nxt = cnt_r;
        end
        if (cap_b_ev) begin
            cap_b_nxt = cnt_r;
        end
        // compare matches and pin levels
        if (pwm_mode || sp_mode) begin
            if (match_a) begin
                pin_a_nxt = ctrl_a_r[TCC_A_LEVEL_A];
                pulse_act_nxt = 1'b0;
            end
            if (pwm_mode && match_b) begin
                pin_a_nxt = ctrl_a_r[TCC_A_LEVEL_B];
                cnt_nxt   = TCC_RST_CNT;
                pwm_a_nxt = cmp_a_r;
                pwm_b_nxt = cmp_b_r;
            end
            if (sp_mode && cap_a_ev) begin
                pin_a_nxt = ctrl_a_r[TCC_A_LEVEL_B];
                cnt_nxt   = TCC_RST_CNT;
                pulse_act_nxt = 1'b1;
            end
        end else begin
            if (match_a) begin
                pin_a_nxt = ctrl_a_r[TCC_A_LEVEL_A];
            end
            if (match_b) begin
                pin_b_nxt = ctrl_a_r[TCC_A_LEVEL_B];
            end
        end
        if (!pwm_mode) begin
            pwm_a_nxt = cmp_a_r;
            pwm_b_nxt = cmp_b_r;
        end
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                TCC_OFS_CTRL_A: begin
                    ctrl_a_nxt = reg_wdata;
                    if (reg_wdata[TCC_A_FORCE_A]) begin
                        pin_a_nxt = reg_wdata[TCC_A_LEVEL_A];
                    end
                    if (reg_wdata[TCC_A_FORCE_B]) begin
                        pin_b_nxt = reg_wdata[TCC_A_LEVEL_B];
                    end
                end
                TCC_OFS_CTRL_B: ctrl_b_nxt = reg_wdata;
                TCC_OFS_STATUS: freeze_nxt = reg_wdata[TCC_S_FREEZE];
                TCC_OFS_CMP_A_HI: begin
                    cmp_a_nxt[15:8] = reg_wdata;
                    inhibit_nxt[0]  = 1'b1;
                end
                TCC_OFS_CMP_A_LO: begin
                    cmp_a_nxt[7:0] = reg_wdata;
                    inhibit_nxt[0] = 1'b0;
                end
                TCC_OFS_CMP_B_HI: begin
                    cmp_b_nxt[15:8] = reg_wdata;
                    inhibit_nxt[1]  = 1'b1;
                end
                TCC_OFS_CMP_B_LO: begin
                    cmp_b_nxt[7:0] = reg_wdata;
                    inhibit_nxt[1] = 1'b0;
                end
                default: ;
            endcase
        end
        if (wr_cnt) begin
            cnt_nxt = TCC_RST_CNT;
            hold_nxt = 1'b0;
        end
        // low byte follows the counter unless held
        if (!hold_nxt) begin
            latch_nxt = cnt_nxt[7:0];
        end
        // outputs: freeze disables both pins, pwm and single-pulse modes also disable pin b
        oe_a_nxt = ctrl_b_r[TCC_B_OUT_A_EN] && !freeze_r;
        oe_b_nxt = ctrl_b_r[TCC_B_OUT_B_EN] && !freeze_r && !pwm_mode && !sp_mode;
        irq_nxt  = !cpu_irq_mask && (
            (ctrl_a_r[TCC_A_CAP_IE] && (flags_r[4] || flags_r[1])) ||
            (ctrl_a_r[TCC_A_CMP_IE] && (flags_r[3] || flags_r[0])) ||
            (ctrl_a_r[TCC_A_OVF_IE] && flags_r[2]));
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_a_r    <= TCC_RST_CTRL;
            ctrl_b_r    <= TCC_RST_CTRL;
            freeze_r    <= 1'b0;
            flags_r     <= 5'h00;
            armed_r     <= 5'h00;
            cnt_r       <= TCC_RST_CNT;
            cap_a_r     <= TCC_CNT_ZERO;
            cap_b_r     <= TCC_CNT_ZERO;
            cmp_a_r     <= TCC_RST_CMP;
            cmp_b_r     <= TCC_RST_CMP;
            pwm_a_r     <= TCC_RST_CMP;
            pwm_b_r     <= TCC_RST_CMP;
            inhibit_r   <= 2'h0;
            latch_r     <= TCC_RST_CNT[7:0];
            hold_r      <= 1'b0;
            pre_r       <= 3'h0;
            prev_r      <= 3'h0;
            pulse_act_r <= 1'b0;
            pin_a_r     <= 1'b0;
            pin_b_r     <= 1'b0;
            oe_a_r      <= 1'b0;
            oe_b_r      <= 1'b0;
            irq_r       <= 1'b0;
            rdata_r     <= 8'h00;
        end else begin
            ctrl_a_r    <= ctrl_a_nxt;
            ctrl_b_r    <= ctrl_b_nxt;
            freeze_r    <= freeze_nxt;
            flags_r     <= flags_nxt;
            armed_r     <= armed_nxt;
            cnt_r       <= cnt_nxt;
            cap_a_r     <= cap_a_nxt;
            cap_b_r     <= cap_b_nxt;
            cmp_a_r     <= cmp_a_nxt;
            cmp_b_r     <= cmp_b_nxt;
            pwm_a_r     <= pwm_a_nxt;
            pwm_b_r     <= pwm_b_nxt;
            inhibit_r   <= inhibit_nxt;
            latch_r     <= latch_nxt;
            hold_r      <= hold_nxt;
            pre_r       <= pre_nxt;
            prev_r      <= prev_nxt;
            pulse_act_r <= pulse_act_nxt;
            pin_a_r     <= pin_a_nxt;
            pin_b_r     <= pin_b_nxt;
            oe_a_r      <= oe_a_nxt;
            oe_b_r      <= oe_b_nxt;
            irq_r       <= irq_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata        = rdata_r;
    assign timer_irq        = irq_r;
    assign compare_a_pin    = pin_a_r;
    assign compare_a_pin_oe = oe_a_r;
    assign compare_b_pin    = pin_b_r;
    assign compare_b_pin_oe = oe_b_r;
endmodule

// file: bench/tcc_timer_assertions.sv
/*
 * tcc_chk: port-level checks of tcc_timer.
 * assumes: bound onto tcc_timer, one clock clk_sys, async reset.
 */
`timescale 1ns/1ps
module tcc_chk
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // cpu side and pins
    input wire logic       cpu_irq_mask,
    input wire logic       timer_irq,
    input wire logic       compare_a_pin,
    input wire logic       compare_a_pin_oe,
    input wire logic       compare_b_pin,
    input wire logic       compare_b_pin_oe
);
    logic [7:0] ctl_a_r;
    logic [7:0] ctl_b_r;
    logic       frz_r;
    // shadow of written control bits
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctl_a_r <= 8'h00;
            ctl_b_r <= 8'h00;
            frz_r   <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == TCC_OFS_CTRL_A) ctl_a_r <= reg_wdata;
            if (reg_addr == TCC_OFS_CTRL_B) ctl_b_r <= reg_wdata;
            if (reg_addr == TCC_OFS_STATUS) frz_r <= reg_wdata[TCC_S_FREEZE];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_irq_masked;
        cpu_irq_mask [*2] |-> !timer_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
    property p_irq_off;
        (ctl_a_r[7:5] == 3'h0) [*2] |-> !timer_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");
    property p_oe_a_off;
        (!ctl_b_r[TCC_B_OUT_A_EN] || frz_r) [*2] |-> !compare_a_pin_oe;
    endproperty
    a_oe_a_off: assert property (p_oe_a_off) else $error("pin a driven while disabled");
    property p_oe_b_off;
        (!ctl_b_r[TCC_B_OUT_B_EN] || frz_r || ctl_b_r[5:4] != 2'h0) [*2] |-> !compare_b_pin_oe;
    endproperty
    a_oe_b_off: assert property (p_oe_b_off) else $error("pin b driven while disabled");
    property p_force_a;
        reg_wr && reg_addr == TCC_OFS_CTRL_A && reg_wdata[TCC_A_FORCE_A] && ctl_b_r[7] && !frz_r
            && ctl_b_r[5:4] == 2'h0 |-> ##[1:2] compare_a_pin == ctl_a_r[TCC_A_LEVEL_A];
    endproperty
    a_force_a: assert property (p_force_a) else $error("force a level missing");
    property p_force_b;
        reg_wr && reg_addr == TCC_OFS_CTRL_A && reg_wdata[TCC_A_FORCE_B] && ctl_b_r[6] && !frz_r
            && ctl_b_r[5:4] == 2'h0 |-> ##[1:2] compare_b_pin == ctl_a_r[TCC_A_LEVEL_B];
    endproperty
    a_force_b: assert property (p_force_b) else $error("force b level missing");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_status_rd;
        reg_rd && reg_addr == TCC_OFS_STATUS |=> reg_rdata[1:0] == 2'h0 && reg_rdata[2] == $past(frz_r);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status low bits wrong");
    property p_unmapped;
        reg_rd && reg_addr == 4'h0 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind tcc_timer tcc_chk u_chk (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_irq_mask, .timer_irq, .compare_a_pin, .compare_a_pin_oe, .compare_b_pin, .compare_b_pin_oe);

// file: bench/tcc_pins.sv
/*
 * tcc_pins: far-side model of the capture and external count pins.
 * assumes: called from the bench, changes pins just after clk_sys edges.
 */
`timescale 1ns/1ps
module tcc_pins (
    // clock
    input wire logic clk_sys,
    // pins toward the timer
    output logic     capture_a_pin,
    output logic     capture_b_pin,
    output logic     ext_count_pin
);
    // idle levels
    initial begin
        capture_a_pin = 1'b0;
        capture_b_pin = 1'b1;
        ext_count_pin = 1'b0;
    end
    // one level change, held past the synchroniser
    task automatic edge_a(input logic v);
        @(posedge clk_sys);
        capture_a_pin <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic edge_b(input logic v);
        @(posedge clk_sys);
        capture_b_pin <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    // n slow rising edges on the count pin
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ext_count_pin <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_count_pin <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
endmodule

// file: bench/tb.sv
/*
 * tb: self-checking bench for tcc_timer.
 * assumes: tcc_pins drives the input pins, tcc_chk is bound to the design.
 */
`timescale 1ns/1ps
module tb
    import tcc_pkg::*;
;
    logic       clk_sys;
    logic       reset;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       cpu_irq_mask;
    logic       timer_irq;
    logic       capture_a_pin;
    logic       capture_b_pin;
    logic       ext_count_pin;
    logic       compare_a_pin;
    logic       compare_a_pin_oe;
    logic       compare_b_pin;
    logic       compare_b_pin_oe;
    logic [7:0] d;
    logic [7:0] lo1;
    logic [7:0] hi_cnt;
    int         miscompares;
    int         samples_checked;

    tcc_timer #(.HAS_EXT_CLK(1'b1)) u_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cpu_irq_mask, .timer_irq, .capture_a_pin, .capture_b_pin, .ext_count_pin,
        .compare_a_pin, .compare_a_pin_oe, .compare_b_pin, .compare_b_pin_oe);
    tcc_pins u_pins (.clk_sys, .capture_a_pin, .capture_b_pin, .ext_count_pin);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        rd(a, d);
        chk8(d & m, exp);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cpu_irq_mask = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        // reset values and unmapped offset
        rdchk(TCC_OFS_CTRL_A, 8'hff, 8'h00);
        rdchk(TCC_OFS_CTRL_B, 8'hff, 8'h00);
        rdchk(TCC_OFS_CMP_A_HI, 8'hff, 8'h80);
        rdchk(TCC_OFS_CMP_A_LO, 8'hff, 8'h00);
        rdchk(TCC_OFS_CMP_B_HI, 8'hff, 8'h80);
        rdchk(TCC_OFS_CMP_B_LO, 8'hff, 8'h00);
        rdchk(4'h0, 8'hff, 8'h00);
        rdchk(TCC_OFS_STATUS, 8'h07, 8'h00);
        // overflow flag, enable, mask and clear order
        tick(40);
        rdchk(TCC_OFS_STATUS, 8'h20, 8'h20);
        chk1(timer_irq, 1'b0);
        wr(TCC_OFS_CTRL_A, 8'h20);
        tick(3);
        chk1(timer_irq, 1'b1);
        @(posedge clk_sys);
        cpu_irq_mask <= 1'b1;
        tick(3);
        chk1(timer_irq, 1'b0);
        @(posedge clk_sys);
        cpu_irq_mask <= 1'b0;
        rdchk(TCC_OFS_STATUS, 8'h20, 8'h20);
        rd(TCC_OFS_ACNT_LO, d);
        tick(2);
        rdchk(TCC_OFS_STATUS, 8'h20, 8'h20);
        rd(TCC_OFS_CNT_LO, d);
        tick(2);
        rdchk(TCC_OFS_STATUS, 8'h20, 8'h00);
        chk1(timer_irq, 1'b0);
        // compare a: high byte alone inhibits, then match drives level
        wr(TCC_OFS_CTRL_A, 8'h01);
        wr(TCC_OFS_CTRL_B, 8'h84);
        wr(TCC_OFS_CMP_A_HI, 8'h00);
        wr(TCC_OFS_CNT_LO, 8'h00);
        tick(60);
        rdchk(TCC_OFS_STATUS, 8'h40, 8'h00);
        chk1(compare_a_pin, 1'b0);
        wr(TCC_OFS_CMP_A_LO, 8'h10);
        wr(TCC_OFS_CNT_LO, 8'h00);
        tick(60);
        chk1(compare_a_pin, 1'b1);
        rdchk(TCC_OFS_STATUS, 8'h40, 8'h40);
        wr(TCC_OFS_CMP_A_LO, 8'h10);
        rdchk(TCC_OFS_STATUS, 8'h40, 8'h00);
        // forced levels on both pins
        wr(TCC_OFS_CTRL_B, 8'hc4);
        wr(TCC_OFS_CTRL_A, 8'h1c);
        tick(3);
        chk1(compare_b_pin, 1'b1);
        chk1(compare_a_pin, 1'b0);
        chk1(compare_a_pin_oe, 1'b1);
        wr(TCC_OFS_CTRL_A, 8'h19);
        tick(3);
        chk1(compare_a_pin, 1'b1);
        chk1(compare_b_pin, 1'b0);
        // freeze holds counter and releases pins
        wr(TCC_OFS_STATUS, 8'h04);
        tick(3);
        chk1(compare_a_pin_oe, 1'b0);
        chk1(compare_b_pin_oe, 1'b0);
        rd(TCC_OFS_CNT_HI, d);
        rd(TCC_OFS_CNT_LO, lo1);
        tick(20);
        rd(TCC_OFS_CNT_HI, d);
        rdchk(TCC_OFS_CNT_LO, 8'hff, lo1);
        wr(TCC_OFS_STATUS, 8'h00);
        // captures on rising a and falling b edges
        wr(TCC_OFS_CTRL_A, 8'h82);
        u_pins.edge_a(1'b1);
        u_pins.edge_b(1'b0);
        tick(2);
        chk1(timer_irq, 1'b1);
        rdchk(TCC_OFS_STATUS, 8'h90, 8'h90);
        rd(TCC_OFS_CAP_A_LO, d);
        rdchk(TCC_OFS_STATUS, 8'h90, 8'h10);
        rd(TCC_OFS_CAP_B_LO, d);
        tick(2);
        chk1(timer_irq, 1'b0);
        // external count, rising edges, wrap from fffc
        wr(TCC_OFS_CTRL_B, 8'h0d);
        wr(TCC_OFS_CNT_LO, 8'h00);
        u_pins.ext_pulses(4);
        tick(10);
        rdchk(TCC_OFS_CNT_HI, 8'hff, 8'h00);
        rdchk(TCC_OFS_CNT_LO, 8'hff, 8'h00);
        rdchk(TCC_OFS_STATUS, 8'h20, 8'h20);
        // pwm with single pulse also set: period 0x10, pulse to 0x04
        wr(TCC_OFS_CMP_A_HI, 8'h00);
        wr(TCC_OFS_CMP_A_LO, 8'h04);
        wr(TCC_OFS_CMP_B_HI, 8'h00);
        wr(TCC_OFS_CMP_B_LO, 8'h10);
        wr(TCC_OFS_CTRL_A, 8'h04);
        wr(TCC_OFS_CTRL_B, 8'hb4);
        wr(TCC_OFS_CNT_LO, 8'h00);
        tick(100);
        hi_cnt = 8'h00;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            hi_cnt = hi_cnt + {7'h00, compare_a_pin};
        end
        chk8(hi_cnt, 8'h10);
        rdchk(TCC_OFS_STATUS, 8'hc8, 8'h80);
        // single pulse on falling capture a edge
        wr(TCC_OFS_CTRL_B, 8'ha4);
        u_pins.edge_a(1'b0);
        tick(0);
        chk1(compare_a_pin, 1'b1);
        tick(30);
        chk1(compare_a_pin, 1'b0);
        rdchk(TCC_OFS_STATUS, 8'h40, 8'h00);
        conclude();
    end
endmodule
